// *** bench/bus_engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Far side: sends the held byte over a random span
module bus_engine_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Held byte present
   input  wire logic tx_valid,
   // Engine state
   output var  logic busy,
   output var  logic tx_done
);
   int seed = 32'h95ace88d;
   int left;
   // Busy while shifting, then one done pulse
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         tx_done <= 1'b0;
         left <= 0;
      end else begin
         tx_done <= 1'b0;
         if (busy && left == 0) begin
            busy <= 1'b0;
            tx_done <= 1'b1;
         end else if (busy) begin
            left <= left - 1;
         end else if (tx_valid && !tx_done) begin
            busy <= 1'b1;
            left <= {$random(seed)} % 5;
         end
      end
   end
endmodule // bus_engine_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2c_status_cfg.svh"
module tb;
   logic ref_clk = 0, rst_n = 0, wr = 0, rd = 0, st = 0, sp = 0, ad = 0, rw = 0, bl = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] bin = 8'h00, tx_byte, m_rx, m_tx;
   logic [31:0] wdata = 32'h0, rdata, exp_rd;
   logic tx_done, busy, tx_valid, enabled, irq, b;
   logic m_en, m_wc, m_ov, m_sp, m_st, m_dir, m_rf, m_tf;
   logic [4:0] m_irq, m_mask;
   int seed = 32'h95ace88d, n_fail = 0, compares = 0, k, a;
   // ==========================
   // Clock, design and far side
   initial forever #10 ref_clk = ~ref_clk;
   i2c_status_flags i2c_status_flags_i (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .START_SEEN(st), .STOP_SEEN(sp),
      .ADDR_DONE(ad), .ADDR_RW(rw), .BYTE_LOADED(bl), .BYTE_IN(bin), .TX_DONE(tx_done),
      .BUSY(busy), .TX_BYTE(tx_byte), .TX_VALID(tx_valid), .ENABLED(enabled), .IRQ(irq));
   bus_engine_model bus_engine_model_i (.clk(ref_clk), .rst_n(rst_n), .tx_valid(tx_valid),
      .busy(busy), .tx_done(tx_done));
   // ==========================
   // Reference model, updated from the inputs seen at each edge
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {m_en, m_wc, m_ov, m_sp, m_st, m_dir, m_rf, m_tf} = '0;
         {m_irq, m_mask, m_rx, m_tx, exp_rd} = '0;
      end else begin
         // Read data shows the state held before this edge
         case (rd ? addr : 4'hf)
            `ADDR_STATUS: exp_rd = {19'h0, m_irq, m_wc, m_ov, 1'b0,
                                    m_sp, m_st, m_dir, m_rf, m_tf};
            `ADDR_RECEIVE: exp_rd = {24'h0, m_rx};
            `ADDR_TRANSMIT: exp_rd = {24'h0, m_tx};
            `ADDR_IRQ_MASK: exp_rd = {27'h0, m_mask};
            `ADDR_CONTROL: exp_rd = {31'h0, m_en};
            default: exp_rd = 32'h0;
         endcase
         b = busy | m_tf;
         // Events count only while enabled before this edge
         if (!m_en) begin
            {m_wc, m_ov, m_sp, m_st, m_dir, m_rf, m_tf, m_irq} = '0;
         end else begin
            if (wr && addr == `ADDR_STATUS) begin
               {m_wc, m_ov} = {m_wc, m_ov} & ~wdata[7:6];
               m_irq = m_irq & ~wdata[12:8];
            end
            if (rd && addr == `ADDR_RECEIVE) m_rf = 1'b0;
            if (tx_done && m_tf) {m_tf, m_irq[4]} = 2'b01;
            if (wr && addr == `ADDR_TRANSMIT && b) m_wc = 1'b1;
            if (wr && addr == `ADDR_TRANSMIT && !b) {m_tf, m_tx} = {1'b1, wdata[7:0]};
            if (st) {m_sp, m_st, m_irq[1]} = 3'b011;
            if (sp) {m_sp, m_st, m_irq[0]} = 3'b101;
            if (ad) {m_dir, m_irq[2]} = {rw, 1'b1};
            if (bl && m_rf) m_ov = 1'b1;
            if (bl) {m_rx, m_rf, m_irq[3]} = {bin, 2'b11};
         end
         if (wr && addr == `ADDR_IRQ_MASK) m_mask = wdata[4:0];
         if (wr && addr == `ADDR_CONTROL) m_en = wdata[0];
      end
   end
   // ==========================
   // Checks where outputs are settled
   task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t read %h want %h", $time, g, e);
      end
   endtask
   task automatic cmp_out(input logic [10:0] g, input logic [10:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t outputs %h want %h", $time, g, e);
      end
   endtask
   always @(negedge ref_clk) begin
      if (rst_n) begin
         cmp_rd(rdata, exp_rd);
         cmp_out({irq, tx_valid, enabled, tx_byte}, {|(m_irq & m_mask), m_tf, m_en, m_tx});
      end
   end
   // ==========================
   // One action per cycle: 0 write, 1 read, 2 start, 3 stop, 4 address, 5 byte, 6 idle
   task automatic step(input int kind, input logic [3:0] ra, input logic [31:0] d);
      @(posedge ref_clk);
      {wr, rd, st, sp, ad, bl} <= (kind < 6) ? 6'b100000 >> kind : 6'h00;
      addr <= ra;
      wdata <= d;
      rw <= d[8];
      bin <= d[7:0];
   endtask
   task automatic test_done;
      $display("counts: compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #(20 * 5000);
      n_fail++;
      test_done;
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (k = 1; k < 6; k++) step(k, 4'h0, 32'h1ff);
      for (k = 0; k < 5; k++) step(1, k[3:0], 32'h0);
      $display("test disabled done");
      step(0, `ADDR_CONTROL, 32'h1);
      repeat (1500) begin
         k = {$random(seed)} % 7;
         a = {$random(seed)} % 8;
         if (k == 0 && a == 1) a = 2;
         step(k, a[3:0], (k == 0 && a == 4) ? 32'h1 : $random(seed));
      end
      $display("test random done");
      step(0, `ADDR_CONTROL, 32'h0);
      for (k = 1; k < 6; k++) step(k, 4'h0, 32'h1ff);
      step(1, `ADDR_STATUS, 32'h0);
      step(6, 4'h0, 32'h0);
      step(6, 4'h0, 32'h0);
      $display("test disable done");
      test_done;
   end
endmodule // tb
`default_nettype wire

// *** hdl/i2c_status_cfg.svh ***
`ifndef I2C_STATUS_CFG_SVH
`define I2C_STATUS_CFG_SVH
// Register indices on the plain port
`define ADDR_STATUS   4'h0
`define ADDR_RECEIVE  4'h1
`define ADDR_TRANSMIT 4'h2
`define ADDR_IRQ_MASK 4'h3
`define ADDR_CONTROL  4'h4
// Status bit positions
`define BIT_WCOL  7
`define BIT_ROV   6
`define BIT_STOP  4
`define BIT_START 3
`define BIT_DIR   2
`define BIT_RFULL 1
`define BIT_TFULL 0
// Bits that software clears by writing one
`define STATUS_W1C 8'hc0
// Interrupt sticky bits: 0 stop, 1 start, 2 address byte, 3 receive, 4 sent
`define IRQ_BITS   5
`define RESET_ZERO 32'h0000_0000
`endif

// *** hdl/i2c_status_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2c_status_cfg.svh"
// How it works
// (R01) Stop flag shows stop was seen last
// (R02) Start flag shows start was seen last
// (R03) Direction flag latched after slave address byte
// (R04) Receive full set on load, cleared on read
// (R05) Transmit full set on write, cleared when sent
// (R06) Transmit write while busy sets collision flag
// (R07) Load while receive full sets overflow flag
// (R08) All flags zero after reset and while disabled
module i2c_status_flags (
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   // Register port
   input  wire logic [3:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output var  logic [31:0] RDATA,
   // Bus engine events
   input  wire logic        START_SEEN,
   input  wire logic        STOP_SEEN,
   input  wire logic        ADDR_DONE,
   input  wire logic        ADDR_RW,
   input  wire logic        BYTE_LOADED,
   input  wire logic [7:0]  BYTE_IN,
   input  wire logic        TX_DONE,
   input  wire logic        BUSY,
   // To bus engine
   output var  logic [7:0]  TX_BYTE,
   output var  logic        TX_VALID,
   output var  logic        ENABLED,
   // Interrupt
   output var  logic        IRQ
);
   // ==========================================================
   // State
   i2c_status_pkg::cond_t cond;
   logic        enable;
   logic        dir;
   logic        rfull;
   logic        tfull;
   logic        wcol;
   logic        rov;
   logic [7:0]  rx_hold;
   logic [7:0]  tx_hold;
   logic [`IRQ_BITS-1:0] irq_mask;
   logic [`IRQ_BITS-1:0] irq_stat;
   logic [`IRQ_BITS-1:0] irq_ev;
   logic        wr_stat;
   logic        rd_rcv;
   logic        wr_trn;
   logic        tx_ok;

   // Decoded accesses
   assign wr_stat = WR && (ADDR == `ADDR_STATUS);
   assign rd_rcv  = RD && (ADDR == `ADDR_RECEIVE);
   assign wr_trn  = WR && (ADDR == `ADDR_TRANSMIT);
   assign tx_ok   = wr_trn && !BUSY && !tfull;

   // ==========================================================
   // Module enable
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         enable <= 1'b0;
      end else if (WR && (ADDR == `ADDR_CONTROL)) begin
         enable <= WDATA[0];
      end
   end
   assign ENABLED = enable;

   // Last bus condition; stop wins if both arrive together
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cond <= i2c_status_pkg::COND_NONE;
      end else if (!enable) begin
         cond <= i2c_status_pkg::COND_NONE; // R08
      end else if (STOP_SEEN) begin
         cond <= i2c_status_pkg::COND_STOP; // R01
      end else if (START_SEEN) begin
         cond <= i2c_status_pkg::COND_START; // R02
      end
   end

   // Direction from address byte
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dir <= 1'b0;
      end else if (!enable) begin
         dir <= 1'b0; // R08
      end else if (ADDR_DONE) begin
         dir <= ADDR_RW; // R03
      end
   end

   // Receive holding register and full flag; load wins over read
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rfull   <= 1'b0;
         rx_hold <= 8'h00;
      end else if (!enable) begin
         rfull   <= 1'b0; // R08
      end else if (BYTE_LOADED) begin
         rfull   <= 1'b1; // R04
         rx_hold <= BYTE_IN;
      end else if (rd_rcv) begin
         rfull   <= 1'b0; // R04
      end
   end

   // Transmit holding register; an accepted write wins over completion
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tfull   <= 1'b0;
         tx_hold <= 8'h00;
      end else if (!enable) begin
         tfull   <= 1'b0; // R08
      end else if (tx_ok) begin
         tfull   <= 1'b1; // R05
         tx_hold <= WDATA[7:0];
      end else if (TX_DONE) begin
         tfull   <= 1'b0; // R05
      end
   end
   assign TX_BYTE  = tx_hold;
   assign TX_VALID = tfull;

   // ==========================================================
   // Error flags, write one to clear
   sticky_flag u_wcol (
      .clk    (REF_CLK),
      .rst_n  (RST_N),
      .enable (enable),
      .set    (wr_trn && (BUSY || tfull)), // R06
      .clear  (wr_stat && WDATA[`BIT_WCOL]),
      .flag   (wcol)
   );
   sticky_flag u_rov (
      .clk    (REF_CLK),
      .rst_n  (RST_N),
      .enable (enable),
      .set    (BYTE_LOADED && rfull), // R07
      .clear  (wr_stat && WDATA[`BIT_ROV]),
      .flag   (rov)
   );

   // ==========================================================
   // Interrupt status and mask
   assign irq_ev = {TX_DONE && tfull, BYTE_LOADED, ADDR_DONE, START_SEEN, STOP_SEEN};
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_BITS; gi++) begin : g_irq
         sticky_flag u_irq (
            .clk    (REF_CLK),
            .rst_n  (RST_N),
            .enable (enable),
            .set    (irq_ev[gi]),
            .clear  (wr_stat && WDATA[8+gi]),
            .flag   (irq_stat[gi])
         );
      end
   endgenerate
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_mask <= '0;
      end else if (WR && (ADDR == `ADDR_IRQ_MASK)) begin
         irq_mask <= WDATA[`IRQ_BITS-1:0];
      end
   end
   assign IRQ = |(irq_stat & irq_mask);

   // ==========================================================
   // Read data, one cycle after the strobe
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= `RESET_ZERO;
      end else if (!RD) begin
         RDATA <= `RESET_ZERO;
      end else if (ADDR == `ADDR_STATUS) begin
         RDATA <= {19'h0, irq_stat, wcol, rov, 1'b0,
                   cond == i2c_status_pkg::COND_STOP,
                   cond == i2c_status_pkg::COND_START, dir, rfull, tfull}; // R01 R02
      end else if (ADDR == `ADDR_RECEIVE) begin
         RDATA <= {24'h0, rx_hold};
      end else if (ADDR == `ADDR_TRANSMIT) begin
         RDATA <= {24'h0, tx_hold};
      end else if (ADDR == `ADDR_IRQ_MASK) begin
         RDATA <= {27'h0, irq_mask};
      end else if (ADDR == `ADDR_CONTROL) begin
         RDATA <= {31'h0, enable};
      end else begin
         RDATA <= `RESET_ZERO;
      end
   end

   // ==========================================================
   // Checks
   a_stop_last: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      enable && STOP_SEEN |=> cond == i2c_status_pkg::COND_STOP) // R01
      else $error("stop flag not set");
   a_start_last: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      enable && START_SEEN && !STOP_SEEN |=> cond == i2c_status_pkg::COND_START) // R02
      else $error("start flag not set");
   a_dir_latch: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      enable && ADDR_DONE |=> dir == $past(ADDR_RW)) // R03
      else $error("direction not latched");
   a_rfull_read: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      enable && rd_rcv && !BYTE_LOADED |=> !rfull) // R04
      else $error("receive full not cleared");
   a_tfull_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      enable && tx_ok |=> tfull && TX_BYTE == $past(WDATA[7:0])) // R05
      else $error("transmit full not set");
   a_wcol_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      enable && wr_trn && BUSY |=> wcol && $stable(TX_BYTE)) // R06
      else $error("collision not flagged");
   a_rov_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      enable && BYTE_LOADED && rfull |=> rov) // R07
      else $error("overflow not flagged");
   a_disabled_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !enable |=> !enable || (!rfull && !tfull && !wcol && !rov && !dir && irq_stat == '0
         && cond == i2c_status_pkg::COND_NONE)) // R08
      else $error("flags not cleared while disabled");
endmodule // i2c_status_flags
`default_nettype wire

// *** hdl/i2c_status_pkg.sv ***
`default_nettype none
package i2c_status_pkg;
   // Last bus condition seen
   typedef enum logic [1:0] {
      COND_NONE  = 2'b00,
      COND_START = 2'b01,
      COND_STOP  = 2'b10
   } cond_t;
endpackage
`default_nettype wire

// *** hdl/sticky_flag.sv ***
`timescale 1ns/1ps
`default_nettype none
// One sticky flag: hardware set wins over software clear
module sticky_flag (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic enable,
   input  wire logic set,
   input  wire logic clear,
   // State
   output var  logic flag
);
   // Set has priority over clear; disabled module forces zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (!enable) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clear) begin
         flag <= 1'b0;
      end
   end
endmodule // sticky_flag
`default_nettype wire
